// ### rtl/bcd_map.vh
/*
 Constants for the bridge command decoder: command codes, configuration
 address fields, result encodings and decoder states.
 Assumes nothing beyond being included by the decoder files.
*/
`ifndef BCD_MAP_VH
`define BCD_MAP_VH

// Bus command codes
`define BCD_CMD_INTACK   4'h0
`define BCD_CMD_SPECIAL  4'h1
`define BCD_CMD_IO_RD    4'h2
`define BCD_CMD_IO_WR    4'h3
`define BCD_CMD_RSV4     4'h4
`define BCD_CMD_RSV5     4'h5
`define BCD_CMD_MEM_RD   4'h6
`define BCD_CMD_MEM_WR   4'h7
`define BCD_CMD_RSV8     4'h8
`define BCD_CMD_RSV9     4'h9
`define BCD_CMD_CFG_RD   4'hA
`define BCD_CMD_CFG_WR   4'hB
`define BCD_CMD_MEM_RDM  4'hC
`define BCD_CMD_DAC      4'hD
`define BCD_CMD_MEM_RDL  4'hE
`define BCD_CMD_MEM_WI   4'hF

// Configuration address fields
`define BCD_AD_TYPE_HI   1
`define BCD_AD_TYPE_LO   0
`define BCD_AD_TYPE0     2'h0
`define BCD_AD_TYPE1     2'h1
`define BCD_AD_BUS_HI    23
`define BCD_AD_BUS_LO    16
`define BCD_AD_DEV_HI    15
`define BCD_AD_DEV_LO    11
`define BCD_AD_FUNC_HI   10
`define BCD_AD_FUNC_LO   8
`define BCD_SPC_DEV      5'h1F
`define BCD_SPC_FUNC     3'h7

// Conversion applied to a forwarded cycle
`define BCD_XLAT_NONE    2'h0
`define BCD_XLAT_TYPE0   2'h1
`define BCD_XLAT_SPECIAL 2'h2

// Packed decode result
`define BCD_RES_W        9
`define BCD_RES_CLAIM    8
`define BCD_RES_INT      7
`define BCD_RES_FWD      6
`define BCD_RES_XL_HI    5
`define BCD_RES_XL_LO    4
`define BCD_RES_CMD_HI   3
`define BCD_RES_CMD_LO   0
`define BCD_RES_NONE     9'h000

// Decoder states
`define BCD_ST_IDLE      2'h0
`define BCD_ST_WAIT      2'h1
`define BCD_ST_DAC       2'h2

// Side index
`define BCD_SIDE_UP      0
`define BCD_SIDE_DN      1

`endif

// ### rtl/bcd_cfg_fields.v
/*
 Splits a configuration address phase into its type, bus, device and
 function fields and flags a special-cycle request.
 Assumes the address is stable in the cycle it is examined.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bcd_map.vh"

module bcd_cfg_fields (
  // Address phase
  input  wire [31:0] ad,
  // Fields
  output wire        is_type0,
  output wire        is_type1,
  output wire [7:0]  bus,
  output wire [2:0]  func,
  output wire        spc_req
);

  wire [4:0] dev;

  assign is_type0 = (ad[`BCD_AD_TYPE_HI:`BCD_AD_TYPE_LO] == `BCD_AD_TYPE0);
  assign is_type1 = (ad[`BCD_AD_TYPE_HI:`BCD_AD_TYPE_LO] == `BCD_AD_TYPE1);
  assign bus      = ad[`BCD_AD_BUS_HI:`BCD_AD_BUS_LO];
  assign dev      = ad[`BCD_AD_DEV_HI:`BCD_AD_DEV_LO];
  assign func     = ad[`BCD_AD_FUNC_HI:`BCD_AD_FUNC_LO];
  // Only a type 1 address carries a device number for the request
  assign spc_req  = is_type1 && (dev == `BCD_SPC_DEV) && (func == `BCD_SPC_FUNC);

endmodule // bcd_cfg_fields

`default_nettype wire

// ### rtl/bcd_bus_cmp.v
/*
 Compares a target bus number against the programmed primary,
 secondary and subordinate bus numbers.
 Assumes the bus number settings are static while a cycle decodes.
*/
`timescale 1ns/100ps
`default_nettype none

module bcd_bus_cmp (
  // Target and settings
  input  wire [7:0] bus,
  input  wire [7:0] pri_bus,
  input  wire [7:0] sec_bus,
  input  wire [7:0] sub_bus,
  // Results
  output wire       eq_pri,
  output wire       eq_sec,
  output wire       behind,
  output wire       in_range
);

  assign eq_pri   = (bus == pri_bus);
  assign eq_sec   = (bus == sec_bus);
  assign in_range = (bus >= sec_bus) && (bus <= sub_bus);
  assign behind   = (bus > sec_bus) && (bus <= sub_bus);

endmodule // bcd_bus_cmp

`default_nettype wire

// ### rtl/bcd_cmd_decode.v
/*
 Command decoder of a two-port bus bridge: decides per address phase on
 the upstream and downstream bus whether to claim, serve internally or
 forward, and which conversion applies.
 Assumes address window hits come from outside logic on the same clock,
 qualified by a hit-valid strobe, and that bus number settings are held
 in the bridge configuration logic.

*/
`timescale 1ns/100ps
`default_nettype none
`include "bcd_map.vh"

module bcd_cmd_decode (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Bus number settings
  input  wire [7:0]  pri_bus,
  input  wire [7:0]  sec_bus,
  input  wire [7:0]  sub_bus,
  // Upstream address phase
  input  wire        up_addr_valid,
  input  wire [3:0]  upstream_cmd_byte_en,
  input  wire [31:0] up_ad,
  input  wire        up_cyc_end,
  input  wire        up_idsel,
  input  wire [7:0]  up_func_impl,
  // Upstream window hits
  input  wire        up_hit_valid,
  input  wire        up_io_hit,
  input  wire        up_mem_hit,
  input  wire        up_mmio_hit,
  // Downstream address phase
  input  wire        dn_addr_valid,
  input  wire [3:0]  downstream_cmd_byte_en,
  input  wire [31:0] dn_ad,
  input  wire        dn_cyc_end,
  // Downstream window hits
  input  wire        dn_hit_valid,
  input  wire        dn_io_hit,
  input  wire        dn_mem_hit,
  input  wire        dn_mmio_hit,
  // Upstream decision
  output wire        up_done,
  output wire        up_claim,
  output wire        up_internal,
  output wire        up_fwd,
  output wire [1:0]  up_xlat,
  output wire [3:0]  up_out_cmd,
  output wire        up_dac,
  output wire [2:0]  up_cfg_func,
  // Downstream decision
  output wire        dn_done,
  output wire        dn_claim,
  output wire        dn_internal,
  output wire        dn_fwd,
  output wire [1:0]  dn_xlat,
  output wire [3:0]  dn_out_cmd,
  output wire        dn_dac
);

  // Commands that need a window hit before the outcome is known
  function needs_hit;
    input [3:0] cmd;
    begin
      case (cmd)
        `BCD_CMD_IO_RD, `BCD_CMD_IO_WR,
        `BCD_CMD_MEM_RD, `BCD_CMD_MEM_WR,
        `BCD_CMD_MEM_RDM, `BCD_CMD_MEM_RDL, `BCD_CMD_MEM_WI: needs_hit = 1'b1;
        default: needs_hit = 1'b0;
      endcase
    end
  endfunction

  // Full claim decision for one side
  function [`BCD_RES_W-1:0] decide;
    input       side;
    input [3:0] cmd;
    input       t0;
    input       t1;
    input       spc;
    input       eq_pri;
    input       eq_sec;
    input       behind;
    input       in_range;
    input       sel_ok;
    input       io_hit;
    input       mem_hit;
    input       mmio_hit;
    reg         cl;
    reg         it;
    reg         fw;
    reg [1:0]   xl;
    reg [3:0]   oc;
    begin
      cl = 1'b0;
      it = 1'b0;
      fw = 1'b0;
      xl = `BCD_XLAT_NONE;
      oc = cmd;
      case (cmd)
        `BCD_CMD_IO_RD, `BCD_CMD_IO_WR: begin
          fw = io_hit;
        end
        `BCD_CMD_MEM_RD, `BCD_CMD_MEM_WR,
        `BCD_CMD_MEM_RDM, `BCD_CMD_MEM_RDL, `BCD_CMD_MEM_WI: begin
          fw = mem_hit || mmio_hit;
        end
        `BCD_CMD_CFG_RD, `BCD_CMD_CFG_WR: begin
          if (side == `BCD_SIDE_UP) begin
            if (t0) begin
              it = sel_ok;
            end else if (t1 && spc && (cmd == `BCD_CMD_CFG_WR)) begin
              if (eq_sec) begin
                fw = 1'b1;
                xl = `BCD_XLAT_SPECIAL;
                oc = `BCD_CMD_SPECIAL;
              end else begin
                fw = behind;
              end
            end else if (t1) begin
              if (eq_sec) begin
                fw = 1'b1;
                xl = `BCD_XLAT_TYPE0;
              end else begin
                fw = behind;
              end
            end
          end else begin
            // Only special requests cross upstream
            if (t1 && spc && (cmd == `BCD_CMD_CFG_WR)) begin
              if (eq_pri) begin
                fw = 1'b1;
                xl = `BCD_XLAT_SPECIAL;
                oc = `BCD_CMD_SPECIAL;
              end else begin
                fw = !in_range;
              end
            end
          end
        end
        default: begin
          fw = 1'b0;
        end
      endcase
      cl = fw || it;
      decide = {cl, it, fw, xl, oc};
    end
  endfunction

  // Side vectors
  wire [1:0]  addr_valid = {dn_addr_valid, up_addr_valid};
  wire [1:0]  cyc_end    = {dn_cyc_end, up_cyc_end};
  wire [1:0]  hit_valid  = {dn_hit_valid, up_hit_valid};
  wire [1:0]  io_hit     = {dn_io_hit, up_io_hit};
  wire [1:0]  mem_hit    = {dn_mem_hit, up_mem_hit};
  wire [1:0]  mmio_hit   = {dn_mmio_hit, up_mmio_hit};
  wire [7:0]  cmd_in     = {downstream_cmd_byte_en, upstream_cmd_byte_en};
  wire [63:0] ad_in      = {dn_ad, up_ad};

  wire [1:0]                done_w;
  wire [2*`BCD_RES_W-1:0]   res_w;
  wire [1:0]                dac_w;
  wire [5:0]                func_w;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : side_g
      reg [1:0]             st_r;
      reg [1:0]             st_nxt;
      reg [3:0]             cmd_r;
      reg [3:0]             cmd_nxt;
      reg [31:0]            ad_r;
      reg [31:0]            ad_nxt;
      reg                   dacf_r;
      reg                   dacf_nxt;
      reg                   done_r;
      reg                   done_nxt;
      reg [`BCD_RES_W-1:0]  res_r;
      reg [`BCD_RES_W-1:0]  res_nxt;
      reg                   dac_r;
      reg                   dac_nxt;
      reg [2:0]             func_r;
      reg [2:0]             func_nxt;

      // In WAIT the held phase is examined, otherwise the live one
      wire        use_held = (st_r == `BCD_ST_WAIT);
      wire [3:0]  cmd_cur  = use_held ? cmd_r : cmd_in[4*g+3:4*g];
      wire [31:0] ad_cur   = use_held ? ad_r : ad_in[32*g+31:32*g];

      wire        t0;
      wire        t1;
      wire [7:0]  tbus;
      wire [2:0]  tfunc;
      wire        spc;
      wire        eq_pri;
      wire        eq_sec;
      wire        behind;
      wire        in_range;

      bcd_cfg_fields u_fields (
        .ad       (ad_cur),
        .is_type0 (t0),
        .is_type1 (t1),
        .bus      (tbus),
        .func     (tfunc),
        .spc_req  (spc)
      );

      bcd_bus_cmp u_cmp (
        .bus      (tbus),
        .pri_bus  (pri_bus),
        .sec_bus  (sec_bus),
        .sub_bus  (sub_bus),
        .eq_pri   (eq_pri),
        .eq_sec   (eq_sec),
        .behind   (behind),
        .in_range (in_range)
      );

      // Idsel is only wired upstream; downstream never selects the bridge
      wire sel_ok = (g == `BCD_SIDE_UP) ? (up_idsel && up_func_impl[tfunc]) : 1'b0;
      wire [`BCD_RES_W-1:0] dec = decide(g == `BCD_SIDE_DN, cmd_cur, t0, t1, spc,
                                         eq_pri, eq_sec, behind, in_range, sel_ok,
                                         io_hit[g], mem_hit[g], mmio_hit[g]);

      always @* begin
        st_nxt   = st_r;
        cmd_nxt  = cmd_r;
        ad_nxt   = ad_r;
        dacf_nxt = dacf_r;
        done_nxt = 1'b0;
        res_nxt  = res_r;
        dac_nxt  = dac_r;
        func_nxt = func_r;
        case (st_r)
          `BCD_ST_IDLE, `BCD_ST_DAC: begin
            if (cyc_end[g]) begin
              st_nxt   = `BCD_ST_IDLE;
              dacf_nxt = 1'b0;
            end else if (addr_valid[g]) begin
              if (cmd_cur == `BCD_CMD_DAC) begin
                // Low half of a 64-bit address; real command follows
                st_nxt   = `BCD_ST_DAC;
                dacf_nxt = 1'b1;
              end else if (needs_hit(cmd_cur) && !hit_valid[g]) begin
                st_nxt  = `BCD_ST_WAIT;
                cmd_nxt = cmd_cur;
                ad_nxt  = ad_cur;
              end else begin
                st_nxt   = `BCD_ST_IDLE;
                done_nxt = 1'b1;
                res_nxt  = dec;
                dac_nxt  = dacf_r;
                func_nxt = tfunc;
                dacf_nxt = 1'b0;
              end
            end
          end
          `BCD_ST_WAIT: begin
            if (cyc_end[g]) begin
              // Cycle gone before the windows answered: stays unclaimed
              st_nxt   = `BCD_ST_IDLE;
              dacf_nxt = 1'b0;
            end else if (hit_valid[g]) begin
              st_nxt   = `BCD_ST_IDLE;
              done_nxt = 1'b1;
              res_nxt  = dec;
              dac_nxt  = dacf_r;
              func_nxt = tfunc;
              dacf_nxt = 1'b0;
            end
          end
          default: begin
            st_nxt   = `BCD_ST_IDLE;
            dacf_nxt = 1'b0;
          end
        endcase
        // The end of a cycle withdraws the previous decision
        if (cyc_end[g]) begin
          res_nxt = `BCD_RES_NONE;
          dac_nxt = 1'b0;
        end
      end

      always @(posedge clk) begin
        if (rst) begin
          st_r   <= `BCD_ST_IDLE;
          cmd_r  <= `BCD_CMD_INTACK;
          ad_r   <= 32'h00000000;
          dacf_r <= 1'b0;
          done_r <= 1'b0;
          res_r  <= `BCD_RES_NONE;
          dac_r  <= 1'b0;
          func_r <= 3'h0;
        end else begin
          st_r   <= st_nxt;
          cmd_r  <= cmd_nxt;
          ad_r   <= ad_nxt;
          dacf_r <= dacf_nxt;
          done_r <= done_nxt;
          res_r  <= res_nxt;
          dac_r  <= dac_nxt;
          func_r <= func_nxt;
        end
      end

      assign done_w[g]                          = done_r;
      assign res_w[`BCD_RES_W*g+`BCD_RES_W-1:`BCD_RES_W*g] = res_r;
      assign dac_w[g]                           = dac_r;
      assign func_w[3*g+2:3*g]                  = func_r;
    end
  endgenerate

  wire [`BCD_RES_W-1:0] up_res = res_w[`BCD_RES_W-1:0];
  wire [`BCD_RES_W-1:0] dn_res = res_w[2*`BCD_RES_W-1:`BCD_RES_W];

  assign up_done     = done_w[`BCD_SIDE_UP];
  assign up_claim    = up_res[`BCD_RES_CLAIM];
  assign up_internal = up_res[`BCD_RES_INT];
  assign up_fwd      = up_res[`BCD_RES_FWD];
  assign up_xlat     = up_res[`BCD_RES_XL_HI:`BCD_RES_XL_LO];
  assign up_out_cmd  = up_res[`BCD_RES_CMD_HI:`BCD_RES_CMD_LO];
  assign up_dac      = dac_w[`BCD_SIDE_UP];
  assign up_cfg_func = func_w[2:0];

  assign dn_done     = done_w[`BCD_SIDE_DN];
  assign dn_claim    = dn_res[`BCD_RES_CLAIM];
  assign dn_internal = dn_res[`BCD_RES_INT];
  assign dn_fwd      = dn_res[`BCD_RES_FWD];
  assign dn_xlat     = dn_res[`BCD_RES_XL_HI:`BCD_RES_XL_LO];
  assign dn_out_cmd  = dn_res[`BCD_RES_CMD_HI:`BCD_RES_CMD_LO];
  assign dn_dac      = dac_w[`BCD_SIDE_DN];

endmodule // bcd_cmd_decode

`default_nettype wire

// ### sim/bcd_cmd_decode_properties.sv
/*
 Port checks for the bridge command decoder.
 Assumes one clock, synchronous active-high reset, bound from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bcd_map.vh"

module bcd_cmd_decode_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Settings
  input wire logic [7:0]  pri_bus,
  input wire logic [7:0]  sec_bus,
  // Upstream
  input wire logic        up_addr_valid,
  input wire logic [3:0]  upstream_cmd_byte_en,
  input wire logic [31:0] up_ad,
  input wire logic        up_cyc_end,
  input wire logic        up_idsel,
  input wire logic [7:0]  up_func_impl,
  input wire logic        up_done,
  input wire logic        up_claim,
  input wire logic        up_internal,
  input wire logic        up_fwd,
  input wire logic [1:0]  up_xlat,
  // Downstream
  input wire logic        dn_addr_valid,
  input wire logic [3:0]  downstream_cmd_byte_en,
  input wire logic [31:0] dn_ad,
  input wire logic        dn_cyc_end,
  input wire logic        dn_done,
  input wire logic        dn_claim,
  input wire logic        dn_internal,
  input wire logic [1:0]  dn_xlat,
  input wire logic [3:0]  dn_out_cmd
);
  // Phases are only offered in IDLE or DAC state, so no pending window wait is hidden here
  wire       up_take = up_addr_valid && !up_cyc_end;
  wire       dn_take = dn_addr_valid && !dn_cyc_end;
  wire [3:0] uc      = upstream_cmd_byte_en;
  wire [3:0] dc      = downstream_cmd_byte_en;
  wire       sel_ok  = up_idsel && up_func_impl[up_ad[10:8]];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rst_clear_a: assert property (disable iff (1'b0) rst
    |=> !up_done && !up_claim && !dn_claim)
    else $error("outputs not cleared by reset");
  claim_cause_a: assert property ($rose(up_claim) |-> up_done)
    else $error("claim without decision");
  type0_sel_a: assert property (up_take && uc[3:1] == 3'h5 && up_ad[1:0] == 2'h0
    |=> up_done && !up_fwd && up_claim == $past(sel_ok))
    else $error("type 0 decode wrong");
  internal_only_a: assert property (up_internal |-> up_claim && !up_fwd && up_xlat == 2'h0)
    else $error("internal access forwarded");
  sec_read_a: assert property (up_take && uc == `BCD_CMD_CFG_RD && up_ad[1:0] == 2'h1
    && up_ad[23:16] == sec_bus |=> up_done && up_claim && up_xlat == 2'h1)
    else $error("secondary read not converted");
  dac_hold_a: assert property (up_take && uc == `BCD_CMD_DAC |=> !up_done)
    else $error("decision on dual address phase");
  end_clear_a: assert property (up_cyc_end |=> !up_claim && !up_fwd && !up_internal)
    else $error("claim survives cycle end");
  dn_ignore_a: assert property (dn_take
    && (dc[3:1] == 3'h0 || dc == `BCD_CMD_CFG_RD) |=> dn_done && !dn_claim)
    else $error("downstream claimed ignored command");
  dn_spc_pri_a: assert property (dn_take && dc == `BCD_CMD_CFG_WR
    && dn_ad[15:0] == 16'hFF01 && dn_ad[23:16] == pri_bus
    |=> dn_claim && dn_xlat == 2'h2 && dn_out_cmd == 4'h1)
    else $error("upstream special cycle missing");
  dn_done_pulse_a: assert property (dn_done |=> !dn_done)
    else $error("decision strobe too long");
  dn_no_int_a: assert property (!dn_internal)
    else $error("downstream served internally");
endmodule // bcd_cmd_decode_properties
`default_nettype wire

// ### sim/bcd_init_model.sv
/*
 Initiator model for one bus port: address phases, window hits, cycle end.
 Assumes one calling process per port; drives just after the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none

module bcd_init_model (
  // Clock
  input  wire logic        clk,
  // Address phase
  output var  logic        addr_valid,
  output var  logic [3:0]  cmd,
  output var  logic [31:0] ad,
  output var  logic        cyc_end,
  // Window hits, io/mem/mmio
  output var  logic        hit_valid,
  output var  logic [2:0]  hits
);
  initial begin
    {addr_valid, cyc_end, hit_valid} = 3'h0;
    {cmd, ad, hits} = 39'h0;
  end

  // Late 1 gives hits a cycle later, late 2 ends the cycle instead.
  // Outside the strobe the lines carry the inverse so stale values never pass.
  task phase(input [3:0] c, input [31:0] a, input [2:0] h, input [1:0] late);
    begin
      @(posedge clk) #2;
      {addr_valid, cmd, ad} = {1'b1, c, a};
      hit_valid = (late == 2'h0);
      hits = (late == 2'h0) ? h : ~h;
      @(posedge clk) #2;
      {addr_valid, cmd, ad} = {1'b0, ~c, ~a};
      hit_valid = (late == 2'h1);
      hits = (late == 2'h1) ? h : ~h;
      cyc_end = (late == 2'h2);
      if (late != 2'h0) begin
        @(posedge clk) #2;
        {hit_valid, cyc_end, hits} = {2'h0, ~h};
      end
    end
  endtask

  task end_cycle;
    begin
      @(posedge clk) #2 cyc_end = 1'b1;
      @(posedge clk) #2 cyc_end = 1'b0;
    end
  endtask
endmodule // bcd_init_model
`default_nettype wire

// ### sim/bridge_command_decode_test.sv
/*
 Self-checking bench for the bridge command decoder.
 Assumes the decoder, its map header and the initiator model are compiled.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bcd_map.vh"

module bridge_command_decode_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        idsel = 1'b0;
  logic [7:0]  pri = 8'h02, sec = 8'h05, sub = 8'h09, fimpl = 8'h01;
  integer      failures = 0, checks = 0, cycles = 0, n;
  wire         up_av, up_ce, up_hv, dn_av, dn_ce, dn_hv;
  wire [3:0]   up_cmd, dn_cmd, up_oc, dn_oc;
  wire [31:0]  up_a, dn_a;
  wire [2:0]   up_h, dn_h, up_cf;
  wire [1:0]   up_xl, dn_xl;
  wire         up_done, up_claim, up_int, up_fwd, up_dac;
  wire         dn_done, dn_claim, dn_int, dn_fwd, dn_dac;

  bcd_init_model i_up_bus (.clk(clk), .addr_valid(up_av), .cmd(up_cmd), .ad(up_a),
    .cyc_end(up_ce), .hit_valid(up_hv), .hits(up_h));
  bcd_init_model i_dn_bus (.clk(clk), .addr_valid(dn_av), .cmd(dn_cmd), .ad(dn_a),
    .cyc_end(dn_ce), .hit_valid(dn_hv), .hits(dn_h));
  bcd_cmd_decode i_dut (.clk(clk), .rst(rst), .pri_bus(pri), .sec_bus(sec), .sub_bus(sub),
    .up_addr_valid(up_av), .upstream_cmd_byte_en(up_cmd), .up_ad(up_a), .up_cyc_end(up_ce),
    .up_idsel(idsel), .up_func_impl(fimpl), .up_hit_valid(up_hv), .up_io_hit(up_h[2]),
    .up_mem_hit(up_h[1]), .up_mmio_hit(up_h[0]), .dn_addr_valid(dn_av),
    .downstream_cmd_byte_en(dn_cmd), .dn_ad(dn_a), .dn_cyc_end(dn_ce), .dn_hit_valid(dn_hv),
    .dn_io_hit(dn_h[2]), .dn_mem_hit(dn_h[1]), .dn_mmio_hit(dn_h[0]), .up_done(up_done),
    .up_claim(up_claim), .up_internal(up_int), .up_fwd(up_fwd), .up_xlat(up_xl),
    .up_out_cmd(up_oc), .up_dac(up_dac), .up_cfg_func(up_cf), .dn_done(dn_done),
    .dn_claim(dn_claim), .dn_internal(dn_int), .dn_fwd(dn_fwd), .dn_xlat(dn_xl),
    .dn_out_cmd(dn_oc), .dn_dac(dn_dac));

  always #25 clk = ~clk;

  // Runs stay near 1600 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      give_verdict;
    end
  end

  task give_verdict;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task chk(input [15:0] seen, input [15:0] exp, input string m);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0t %s seen %h expected %h", $time, m, seen, exp);
      end
    end
  endtask

  function rng(input [3:0] c);
    rng = c[3:1] == 3'h1 || c[3:1] == 3'h3 || (c >= 4'hC && c != `BCD_CMD_DAC);
  endfunction

  // {claim, internal, fwd, xlat, out_cmd}
  function [8:0] expd(input s, input [3:0] c, input [31:0] a, input [2:0] h);
    reg [7:0] b;
    reg       t1, spc;
    begin
      b = a[23:16];
      t1 = a[1:0] == 2'h1;
      spc = c == `BCD_CMD_CFG_WR && t1 && a[15:8] == 8'hFF;
      expd = 9'h000;
      if (c[3:1] == 3'h1)
        expd = h[2] ? {5'h14, c} : 9'h000;
      else if (rng(c))
        expd = (h[1] | h[0]) ? {5'h14, c} : 9'h000;
      else if (!s && c[3:1] == 3'h5) begin
        if (a[1:0] == 2'h0)
          expd = (idsel && fimpl[a[10:8]]) ? {5'h18, c} : 9'h000;
        else if (t1 && b == sec)
          expd = spc ? {5'h16, 4'h1} : {5'h15, c};
        else if (t1 && b > sec && b <= sub)
          expd = {5'h14, c};
      end else if (s && spc) begin
        if (b == pri)
          expd = {5'h16, 4'h1};
        else if (b < sec || b > sub)
          expd = {5'h14, c};
      end
    end
  endfunction

  task run(input s, input [3:0] c, input [31:0] a, input [2:0] h, input [1:0] late, input dac);
    reg [8:0] e, g;
    begin
      if (dac) begin
        if (s) i_dn_bus.phase(`BCD_CMD_DAC, $urandom, h, 2'h0);
        else i_up_bus.phase(`BCD_CMD_DAC, $urandom, h, 2'h0);
        #1 chk(s ? dn_done : up_done, 0, "dual address decided");
      end
      if (s) i_dn_bus.phase(c, a, h, late);
      else i_up_bus.phase(c, a, h, late);
      #1;
      e = expd(s, c, a, h);
      g = s ? {dn_claim, dn_int, dn_fwd, dn_xl, dn_oc} : {up_claim, up_int, up_fwd, up_xl, up_oc};
      chk(s ? dn_done : up_done, late != 2'h2, "decision strobe");
      if (late != 2'h2) begin
        chk(g[8:6], e[8:6], "claim route");
        if (e[6]) chk(g[5:0], e[5:0], "conversion");
        if (e[7]) chk(up_cf, a[10:8], "function");
        chk(s ? dn_dac : up_dac, dac, "dual address flag");
      end
      if (s) i_dn_bus.end_cycle;
      else i_up_bus.end_cycle;
      #1 chk(s ? dn_claim : up_claim, 0, "claim after end");
    end
  endtask

  task rnd_case(input s);
    reg [3:0]  c;
    reg [31:0] a;
    begin
      c = $urandom;
      a = $urandom;
      if (c == `BCD_CMD_DAC) c = `BCD_CMD_MEM_RD;
      case ($urandom % 4)
        0: a[23:16] = pri;
        1: a[23:16] = sec;
        2: a[23:16] = sub;
        default: ;
      endcase
      if ($urandom % 3 == 0) a[15:8] = 8'hFF;
      if ($urandom % 4 != 0) a[1] = 1'b0;
      idsel = $urandom;
      fimpl = $urandom;
      run(s, c, a, $urandom, rng(c) ? $urandom % 3 : 0, $urandom % 4 == 0);
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #2 rst = 1'b0;
    void'($urandom(78875));
    idsel = 1'b1;
    run(0, `BCD_CMD_CFG_RD, 32'h0005_0001, 3'h0, 2'h0, 1'b0);
    run(0, `BCD_CMD_CFG_WR, 32'h0005_FF01, 3'h0, 2'h0, 1'b0);
    run(0, `BCD_CMD_CFG_WR, 32'h0009_FF01, 3'h0, 2'h0, 1'b0);
    run(0, `BCD_CMD_CFG_RD, 32'h000A_0001, 3'h0, 2'h0, 1'b0);
    run(0, `BCD_CMD_CFG_RD, 32'h0000_0100, 3'h0, 2'h0, 1'b0);
    run(0, `BCD_CMD_CFG_WR, 32'h0000_0000, 3'h0, 2'h0, 1'b0);
    run(1, `BCD_CMD_CFG_WR, 32'h0002_FF01, 3'h0, 2'h0, 1'b0);
    run(1, `BCD_CMD_CFG_WR, 32'h0005_FF01, 3'h0, 2'h0, 1'b0);
    run(1, `BCD_CMD_CFG_WR, 32'h0010_FF01, 3'h0, 2'h0, 1'b0);
    run(1, `BCD_CMD_CFG_WR, 32'h0010_0001, 3'h0, 2'h0, 1'b0);
    run(0, `BCD_CMD_MEM_RD, 32'h1000_0000, 3'h1, 2'h1, 1'b1);
    run(1, `BCD_CMD_IO_RD, 32'h0000_1000, 3'h3, 2'h2, 1'b0);
    for (n = 0; n < 32; n = n + 1)
      if (n % 16 != 13) run(n / 16, n % 16, 32'h0005_FF01, 3'h7, 2'h0, 1'b0);
    for (n = 0; n < 300; n = n + 1) begin
      // Bus numbers move under the decoder between cycles
      if (n % 50 == 0) begin
        pri = $urandom % 64;
        sec = pri + 8'h01 + $urandom % 8;
        sub = sec + $urandom % 8;
      end
      rnd_case($urandom % 2);
    end
    give_verdict;
  end
endmodule // bridge_command_decode_test

bind bcd_cmd_decode bcd_cmd_decode_properties i_props (.clk, .rst, .pri_bus, .sec_bus,
  .up_addr_valid, .upstream_cmd_byte_en, .up_ad, .up_cyc_end, .up_idsel, .up_func_impl,
  .up_done, .up_claim, .up_internal, .up_fwd, .up_xlat, .dn_addr_valid,
  .downstream_cmd_byte_en, .dn_ad, .dn_cyc_end, .dn_done, .dn_claim, .dn_internal,
  .dn_xlat, .dn_out_cmd);
`default_nettype wire
